// >>> verilog/nvm_ctrl_defines.vh
`ifndef NVM_CTRL_DEFINES_VH
`define NVM_CTRL_DEFINES_VH
// I/O space register addresses (6-bit I/O address)
`define NVM_ADDR_CTRL 6'h1f
`define NVM_ADDR_DATA 6'h20
`define NVM_ADDR_ADRL 6'h21
`define NVM_ADDR_ADRH 6'h22
`define NVM_ADDR_STAT 6'h23
`define NVM_ADDR_IEN 6'h24
`define NVM_ADDR_ICLR 6'h25
// Control register fields
`define CTRL_READ 0
`define CTRL_GO 1
`define CTRL_ARM 2
`define CTRL_RIE 3
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5
// Mode encodings
`define MODE_ATOMIC 2'h0
`define MODE_ERASE 2'h1
`define MODE_WRITE 2'h2
// Status bits
`define STAT_DONE 0
`define STAT_REFUSED 1
// Timing
`define ARM_WINDOW 3'h4
`define READ_STALL 3'h4
`define PROG_STALL 3'h2
`define CAL_DIV 5'h19
`define PROG_ATOMIC_US 3400
`define PROG_SPLIT_US 1800
`define CAL_RATE_MHZ 8
`endif

// >>> verilog/nvm_prog_timer.v
`timescale 1ns/100ps
`include "nvm_ctrl_defines.vh"
module nvm_prog_timer #(
  parameter ATOMIC_TICKS = `PROG_ATOMIC_US * `CAL_RATE_MHZ,
  parameter SPLIT_TICKS = `PROG_SPLIT_US * `CAL_RATE_MHZ
) (
  input wire clk,
  input wire calTick,
  input wire start,
  input wire shortRun,
  output reg running,
  output reg doneP
);
  reg [15:0] cnt;
  // Counts only on calibrated-oscillator ticks, not on clk cycles
  always @(posedge clk)
  begin
    doneP <= 1'b0;
    if (start)
    begin
      running <= 1'b1;
      cnt <= shortRun ? SPLIT_TICKS[15:0] : ATOMIC_TICKS[15:0];
    end
    else if (running && calTick)
    begin
      if (cnt <= 16'h0001)
      begin
        running <= 1'b0;
        doneP <= 1'b1;
      end
      cnt <= cnt - 16'h0001;
    end
  end
  // Running and counter have no reset: programming survives a reset
  initial running = 1'b0;
  initial cnt = 16'h0000;
  initial doneP = 1'b0;
endmodule // nvm_prog_timer

// >>> verilog/nvm_byte_ctrl.v
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "nvm_ctrl_defines.vh"
// How it works
// - A read of the array stalls the processor four clock cycles.
// - Triggering programming stalls the processor two clock cycles.
// - Mode zero plus go within four cycles of arm starts erase and write.
// - Go bit reads one while programming, cleared by hardware at completion.
// - Any other array access is refused while programming runs.
// - Mode 01 with armed go performs erase only.
// - Mode 10 with armed go writes data without erase.
// - Programming time comes from the calibrated oscillator tick, not clk.
// - A reset during programming lets the operation finish.
// - Address, data and control sit in the I/O register space.
// - Hardware clears the arm bit four cycles after software sets it.
// - Mode writes are ignored while the go bit is set.
// - While programming, read strobe only sets the refused status bit and address writes are ignored.
// - With ready enable set, a level interrupt stays high while idle.
module nvm_byte_ctrl #(
  parameter ATOMIC_TICKS = `PROG_ATOMIC_US * `CAL_RATE_MHZ,
  parameter SPLIT_TICKS = `PROG_SPLIT_US * `CAL_RATE_MHZ
) (
  input wire clk,
  input wire rst_n,
  input wire [5:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire ioWr,
  input wire ioRd,
  output reg [7:0] ioRdata,
  output reg cpuStall,
  output reg readyIrq,
  output reg irq
);
  reg [8:0] nvmArray [0:511];
  reg [7:0] nvm_byte_data_q;
  reg [8:0] nvm_byte_address_q;
  reg [1:0] program_mode_sel_q;
  reg ready_irq_enable_q;
  reg program_arm_q;
  reg [2:0] armCnt_q;
  reg [2:0] stallCnt_q;
  reg [4:0] divCnt_q;
  reg calTick_q;
  reg [1:0] opMode_q;
  reg [1:0] stat_q;
  reg [1:0] statEn_q;
  reg [7:0] rdNext;
  wire busy;
  wire doneP;
  wire wrCtrl;
  wire goReq;
  wire rdReq;
  wire [1:0] statSet;
  integer i;

  // Returns true on a write to the given I/O address
  function isWrite;
    input [5:0] a;
    input [5:0] target;
    input w;
    begin
      isWrite = w && (a == target);
    end
  endfunction

  assign wrCtrl = isWrite(ioAddr, `NVM_ADDR_CTRL, ioWr);
  // Go accepted only inside live arm window, idle array
  assign goReq = wrCtrl && ioWdata[`CTRL_GO] && program_arm_q && !busy;
  // Read strobe ignored while programming
  assign rdReq = wrCtrl && ioWdata[`CTRL_READ] && !busy;
  assign statSet = {wrCtrl && (ioWdata[`CTRL_READ] || ioWdata[`CTRL_GO]) && busy, doneP};

  // Calibrated oscillator stand-in: divided enable pulse
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      divCnt_q <= 5'h00;
      calTick_q <= 1'b0;
    end
    else
    begin
      calTick_q <= (divCnt_q == `CAL_DIV - 5'h01);
      divCnt_q <= (divCnt_q == `CAL_DIV - 5'h01) ? 5'h00 : divCnt_q + 5'h01;
    end
  end

  // Self-timed programming; not reset so it runs through reset
  nvm_prog_timer #(
    .ATOMIC_TICKS(ATOMIC_TICKS),
    .SPLIT_TICKS(SPLIT_TICKS)
  ) u_timer (
    .clk(clk),
    .calTick(calTick_q),
    .start(goReq),
    .shortRun(program_mode_sel_q != `MODE_ATOMIC),
    .running(busy),
    .doneP(doneP)
  );

  // Array update at completion; op latched so reset cannot change it
  always @(posedge clk)
  begin
    if (goReq)
      opMode_q <= program_mode_sel_q;
    if (doneP)
    begin
      case (opMode_q)
        `MODE_ATOMIC: nvmArray[nvm_byte_address_q] <= {1'b0, nvm_byte_data_q};
        `MODE_ERASE: nvmArray[nvm_byte_address_q] <= 9'h0ff;
        // Bits can only be cleared; unerased target gives mixed data
        `MODE_WRITE: nvmArray[nvm_byte_address_q] <= {1'b0, nvmArray[nvm_byte_address_q][7:0] & nvm_byte_data_q};
        default: nvmArray[nvm_byte_address_q] <= nvmArray[nvm_byte_address_q];
      endcase
    end
  end

  initial
  begin
    opMode_q = 2'h0;
    for (i = 0; i < 512; i = i + 1)
      nvmArray[i] = 9'h0ff;
  end

  // Address and data registers; both frozen while busy
  // Data is kept through reset too, else a reset mid-program stores zero
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      if (!busy)
      begin
        nvm_byte_data_q <= 8'h00;
        nvm_byte_address_q <= 9'h000;
      end
    end
    else
    begin
      if (rdReq)
        nvm_byte_data_q <= nvmArray[nvm_byte_address_q][7:0];
      else if (isWrite(ioAddr, `NVM_ADDR_DATA, ioWr) && !busy)
        nvm_byte_data_q <= ioWdata;
      if (isWrite(ioAddr, `NVM_ADDR_ADRL, ioWr) && !busy)
        nvm_byte_address_q[7:0] <= ioWdata;
      if (isWrite(ioAddr, `NVM_ADDR_ADRH, ioWr) && !busy)
        nvm_byte_address_q[8] <= ioWdata[0];
    end
  end

  // Control fields, arm window mode lock
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ready_irq_enable_q <= 1'b0;
      program_arm_q <= 1'b0;
      armCnt_q <= 3'h0;
      if (!busy)
        program_mode_sel_q <= `MODE_ATOMIC;
    end
    else
    begin
      if (wrCtrl)
      begin
        ready_irq_enable_q <= ioWdata[`CTRL_RIE];
        if (!busy && !goReq)
          program_mode_sel_q <= ioWdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
      end
      if (wrCtrl && ioWdata[`CTRL_ARM] && !goReq)
      begin
        program_arm_q <= 1'b1;
        armCnt_q <= `ARM_WINDOW;
      end
      else if (goReq || armCnt_q <= 3'h1)
      begin
        program_arm_q <= 1'b0;
        armCnt_q <= 3'h0;
      end
      else
        armCnt_q <= armCnt_q - 3'h1;
    end
  end

  // CPU stall counter: four on read, two on program trigger
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      stallCnt_q <= 3'h0;
      cpuStall <= 1'b0;
    end
    else if (rdReq)
    begin
      stallCnt_q <= `READ_STALL - 3'h1;
      cpuStall <= 1'b1;
    end
    else if (goReq)
    begin
      stallCnt_q <= `PROG_STALL - 3'h1;
      cpuStall <= 1'b1;
    end
    else if (stallCnt_q != 3'h0)
    begin
      stallCnt_q <= stallCnt_q - 3'h1;
      cpuStall <= 1'b1;
    end
    else
      cpuStall <= 1'b0;
  end

  // Sticky status: set wins over clear in the same cycle
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      stat_q <= 2'h0;
      statEn_q <= 2'h0;
    end
    else
    begin
      if (isWrite(ioAddr, `NVM_ADDR_IEN, ioWr))
        statEn_q <= ioWdata[1:0];
      if (isWrite(ioAddr, `NVM_ADDR_ICLR, ioWr))
        stat_q <= (stat_q & ~ioWdata[1:0]) | statSet;
      else
        stat_q <= stat_q | statSet;
    end
  end

  // Read mux; go bit shows busy
  always @*
  begin
    rdNext = 8'h00;
    case (ioAddr)
      `NVM_ADDR_CTRL: rdNext = {2'h0, program_mode_sel_q, ready_irq_enable_q, program_arm_q, busy, 1'b0};
      `NVM_ADDR_DATA: rdNext = nvm_byte_data_q;
      `NVM_ADDR_ADRL: rdNext = nvm_byte_address_q[7:0];
      `NVM_ADDR_ADRH: rdNext = {7'h00, nvm_byte_address_q[8]};
      `NVM_ADDR_STAT: rdNext = {6'h00, stat_q};
      `NVM_ADDR_IEN: rdNext = {6'h00, statEn_q};
      default: rdNext = 8'h00;
    endcase
  end

  // Registered read data and interrupt outputs
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ioRdata <= 8'h00;
      readyIrq <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      ioRdata <= ioRd ? rdNext : 8'h00;
      readyIrq <= ready_irq_enable_q && !busy && !goReq;
      irq <= |(stat_q & statEn_q);
    end
  end
endmodule // nvm_byte_ctrl

// >>> dv/nvm_byte_ctrl_monitor.sv
`timescale 1ns/100ps
module nvm_byte_ctrl_monitor (
  input wire clk,
  input wire rst_n,
  input wire [5:0] ioAddr,
  input wire [7:0] ioWdata,
  input wire ioWr,
  input wire ioRd,
  input wire [7:0] ioRdata,
  input wire cpuStall,
  input wire readyIrq,
  input wire irq
);
  reg [2:0] arm_q;
  reg rie_q;
  reg ien_q;
  wire ctl = ioWr && ioAddr == 6'h1f;
  // Go seen only when idle; readyIrq stands in for not busy
  wire go = ctl && ioWdata[1] && !ioWdata[2] && readyIrq;
  wire live = arm_q != 3'h0 && arm_q != 3'h5;
  // Arm age: 1..4 live, 5 just expired
  always @(posedge clk)
  begin
    if (!rst_n) arm_q <= 3'h0;
    else if (ctl && ioWdata[2]) arm_q <= 3'h1;
    else if (go || arm_q == 3'h5) arm_q <= 3'h0;
    else if (arm_q != 3'h0) arm_q <= arm_q + 3'h1;
    rie_q <= !rst_n ? 1'b0 : (ctl ? ioWdata[3] : rie_q);
    ien_q <= !rst_n ? 1'b0 : (ioWr && ioAddr == 6'h24 ? |ioWdata : ien_q);
  end
  AST_READ_STALL: assert property (@(posedge clk) disable iff (!rst_n)
    ctl && ioWdata[0] && !ioWdata[1] && readyIrq |=> cpuStall [*4] ##1 !cpuStall) else $error("read stall");
  AST_GO_STALL: assert property (@(posedge clk) disable iff (!rst_n)
    go && live |=> cpuStall [*2] ##1 !cpuStall) else $error("go stall");
  AST_GO_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
    go && live |-> ##[1:3] !readyIrq) else $error("go not busy");
  AST_NO_ARM: assert property (@(posedge clk) disable iff (!rst_n)
    go && arm_q == 3'h0 |=> (!cpuStall && readyIrq) [*3]) else $error("unarmed go acted");
  AST_ARM_EXPIRED: assert property (@(posedge clk) disable iff (!rst_n)
    go && arm_q == 3'h5 |=> !cpuStall ##1 readyIrq) else $error("late go acted");
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(ioRd) |-> ioRdata == 8'h00) else $error("stray read data");
  AST_RIE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    !rie_q && !$past(rie_q) |-> !readyIrq) else $error("ready irq unenabled");
  AST_IRQ_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    !ien_q && !$past(ien_q) |-> !irq) else $error("irq unmasked");
endmodule // nvm_byte_ctrl_monitor
bind nvm_byte_ctrl nvm_byte_ctrl_monitor nvm_byte_ctrl_monitor_inst (.clk(clk), .rst_n(rst_n),
  .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWr(ioWr), .ioRd(ioRd), .ioRdata(ioRdata),
  .cpuStall(cpuStall), .readyIrq(readyIrq), .irq(irq));

// >>> dv/nvm_cpu_model.sv
`timescale 1ns/100ps
module nvm_cpu_model (
  input wire clk,
  input wire cpuStall,
  input wire [7:0] ioRdata,
  output reg [5:0] ioAddr,
  output reg [7:0] ioWdata,
  output reg ioWr,
  output reg ioRd
);
  initial
  begin
    ioAddr = 6'h00;
    ioWdata = 8'h00;
    ioWr = 1'b0;
    ioRd = 1'b0;
  end
  // Released lines flip so stale values never look valid
  task wr(input [5:0] a, input [7:0] d);
    integer n;
    begin
      @(posedge clk);
      ioAddr <= a;
      ioWdata <= d;
      ioWr <= 1'b1;
      @(posedge clk);
      ioWr <= 1'b0;
      ioAddr <= ~a;
      ioWdata <= ~d;
      #1;
      n = 0;
      // Core halted: no access until stall drops
      while (cpuStall && n < 8)
      begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
    end
  endtask
  task rd(input [5:0] a, output [7:0] d);
    begin
      @(posedge clk);
      ioAddr <= a;
      ioRd <= 1'b1;
      @(posedge clk);
      ioRd <= 1'b0;
      ioAddr <= ~a;
      #1;
      d = ioRdata;
    end
  endtask
endmodule // nvm_cpu_model

// >>> dv/nvm_byte_ctrl_test.sv
`timescale 1ns/100ps
module nvm_byte_ctrl_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  wire [5:0] ioAddr;
  wire [7:0] ioWdata;
  wire [7:0] ioRdata;
  wire ioWr, ioRd, cpuStall, readyIrq, irq;
  integer failures = 0;
  integer check_count = 0;
  integer nA, nS;
  reg [7:0] d;
  always #2.5 clk = ~clk;
  // Short programming times keep the run brief
  nvm_byte_ctrl #(.ATOMIC_TICKS(4), .SPLIT_TICKS(2)) nvm_byte_ctrl_inst (.clk(clk), .rst_n(rst_n),
    .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWr(ioWr), .ioRd(ioRd), .ioRdata(ioRdata),
    .cpuStall(cpuStall), .readyIrq(readyIrq), .irq(irq));
  nvm_cpu_model nvm_cpu_model_inst (.clk(clk), .cpuStall(cpuStall), .ioRdata(ioRdata),
    .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWr(ioWr), .ioRd(ioRd));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task w(input [5:0] a, input [7:0] v);
    nvm_cpu_model_inst.wr(a, v);
  endtask
  task rdc(input [5:0] a, input [7:0] e);
    begin
      nvm_cpu_model_inst.rd(a, d);
      chk(d, e);
    end
  endtask
  task pause;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  // Poll go bit; the count shows how long programming took
  task wait_idle(output integer n);
    begin
      n = 0;
      d = 8'h02;
      while (d[1] && n < 300)
      begin
        nvm_cpu_model_inst.rd(6'h1f, d);
        n = n + 1;
      end
      if (n >= 300) failures = failures + 1;
    end
  endtask
  task prog(input [1:0] m);
    begin
      w(6'h1f, {2'b00, m, 4'h8});
      w(6'h1f, {2'b00, m, 4'hc});
      w(6'h1f, {2'b00, m, 4'ha});
    end
  endtask
  task readback(input [7:0] e);
    begin
      w(6'h1f, 8'h09);
      rdc(6'h20, e);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    #25000;
    failures = failures + 1;
    end_sim;
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(6'h23, 8'h00);
    rdc(6'h30, 8'h00);
    w(6'h22, 8'h01);
    w(6'h21, 8'h05);
    w(6'h20, 8'h3c);
    prog(2'h0);
    nvm_cpu_model_inst.rd(6'h1f, d);
    chk({7'h0, d[1]}, 8'h01);
    w(6'h1f, 8'h09);
    w(6'h21, 8'h07);
    w(6'h1f, 8'h38);
    wait_idle(nA);
    rdc(6'h1f, 8'h08);
    rdc(6'h23, 8'h03);
    readback(8'h3c);
    chk({7'h0, readyIrq}, 8'h01);
    w(6'h24, 8'h01);
    pause;
    chk({7'h0, irq}, 8'h01);
    w(6'h24, 8'h00);
    pause;
    chk({7'h0, irq}, 8'h00);
    w(6'h25, 8'h03);
    rdc(6'h23, 8'h00);
    prog(2'h1);
    wait_idle(nS);
    chk({7'h0, nS < nA}, 8'h01);
    readback(8'hff);
    w(6'h20, 8'h5a);
    prog(2'h2);
    wait_idle(nS);
    readback(8'h5a);
    w(6'h1f, 8'h0a);
    rdc(6'h1f, 8'h08);
    w(6'h1f, 8'h0c);
    repeat (3) @(posedge clk);
    w(6'h1f, 8'h0a);
    rdc(6'h1f, 8'h08);
    // Go on the last live cycle, then reset mid-run
    w(6'h20, 8'h96);
    w(6'h1f, 8'h0c);
    repeat (2) @(posedge clk);
    w(6'h1f, 8'h0a);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    nvm_cpu_model_inst.rd(6'h1f, d);
    chk({7'h0, d[1]}, 8'h01);
    wait_idle(nA);
    readback(8'h96);
    end_sim;
  end
endmodule // nvm_byte_ctrl_test
